// ==== rtl/sw_mon_pkg.sv ====
// Purpose: Shared constants and types for the switch monitor serial link.
// Assumes: mclk_i runs at 10 MHz on both ends.
// Notes: Host clock divider and software offsets live here as well.
// Contract
// RULE1: Chip select low carries command and status.
// RULE2: Select fall enables output, latches switches, flag.
// RULE3: Select rise tri-states the serial output.
// RULE4: Select rise applies the shifted command word.
// RULE5: Select rise clears flag unless change while low; code also clears it on a sleep command.
// RULE6: Host moves select only while clock low.
// RULE7: Select fall wakes sleeping device with supply.
// RULE8: Serial input sampled on clock falling edge.
// RULE9: Output updated on rise, host samples fall.
// RULE10: Host keeps clock low while idle.
// RULE11: Select high ignores clock, input; output off.
// RULE12: Host shifts exactly 24 bits per frame.
// RULE13: Open switch reads 0, closed reads 1.
// RULE14: First rise gives bit 24, MSB first; code shifts out bit 23 (INT_FLAG_POS) first.
// RULE15: Enabled input change in Normal pulls flag low.
// RULE16: Only the raising device reports flag set.
// RULE17: Shared flag fall wakes all devices.
// RULE18: Wake line low in Normal, released in Sleep.
// RULE19: Wake line fall wakes, gated by flag high; code applies the flag gate only with interface supply.
// RULE20: Select or flag wake needs interface supply.
// RULE21: Dual inputs: battery closed above, ground below.
// RULE22: Ground inputs closed below threshold, no option.
// RULE23: Every response carries switches and both flags.
// RULE24: Closed dual input always reports as 1.
package sw_mon_pkg;

    localparam int FRAME_BITS     = 24;
    localparam int NUM_DUAL       = 8;
    localparam int NUM_GND        = 14;
    localparam int NUM_SW         = 22;
    localparam int INT_FLAG_POS   = 23;
    localparam int THERM_FLAG_POS = 22;

    localparam logic [7:0] CMD_SETTINGS = 8'h01;
    localparam logic [7:0] CMD_WAKE_INT = 8'h02;
    localparam logic [7:0] CMD_SLEEP    = 8'h03;

    localparam logic [NUM_DUAL-1:0] POL_RESET     = 8'hff;
    localparam logic [NUM_SW-1:0]   WAKE_EN_RESET = 22'h3fffff;

    localparam int MCLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 1600;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);

    localparam logic [3:0] ADDR_CMD    = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_RX     = 4'h8;
    localparam logic [3:0] ADDR_LINE   = 4'hc;

    typedef enum logic {MODE_NORMAL, MODE_SLEEP} mode_t;
    typedef enum logic [2:0] {
        H_IDLE, H_LEAD, H_HIGH, H_LOW, H_LAG, H_GAP
    } host_state_t;

endpackage

// ==== rtl/sw_mon_if.sv ====
// Purpose: Pin-level link between the switch monitor and its host.
// Assumes: Open-drain lines have pull-ups; wire level is resolved here.
// Notes: An enable high means that end pulls the line low or drives it.
`timescale 1ns/10ps
interface sw_mon_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic int_oe;
    logic wake_oe;
    logic wake_ext_oe;
    logic int_n;
    logic wake_n;

    assign int_n  = ~int_oe;
    assign wake_n = ~(wake_oe | wake_ext_oe);

    modport device (
        input  cs_n, sclk, si, int_n, wake_n,
        output so, so_oe, int_oe, wake_oe
    );
    modport host (
        input  so, so_oe, int_n, wake_n,
        output cs_n, sclk, si, wake_ext_oe
    );
endinterface

// ==== rtl/sw_mon_host.sv ====
// Purpose: Host end; runs one 24-bit frame per write to the command word.
// Assumes: Software port with one-cycle strobes, read data a cycle later.
// Notes: Starts while busy are dropped; poll the status word first.
`timescale 1ns/10ps
module sw_mon_host
    import sw_mon_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Software port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Link
    sw_mon_if.host           link
);
    host_state_t      state_q;
    logic [3:0]       div_q;
    logic [4:0]       bit_cnt_q;
    logic [23:0]      tx_q;
    logic [23:0]      rx_q;
    logic             cs_n_q;
    logic             sclk_q;
    logic             si_q;
    logic             wake_pull_q;
    logic [2:0]       sync1_q;
    logic [2:0]       sync2_q;
    logic             tick;

    assign tick             = (div_q == 4'(SCLK_HALF_CYC - 1));
    assign link.cs_n        = cs_n_q;
    assign link.sclk        = sclk_q;
    assign link.si          = si_q;
    assign link.wake_ext_oe = wake_pull_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {link.so, link.int_n, link.wake_n};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
        end else if (state_q == H_IDLE || tick) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // Select moves only in LEAD entry and LAG exit, both with clock low.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= H_IDLE;
            cs_n_q    <= 1'b1;
            sclk_q    <= 1'b0;
            si_q      <= 1'b0;
            tx_q      <= 24'h0;
            rx_q      <= 24'h0;
            bit_cnt_q <= 5'h0;
        end else begin
            unique case (state_q)
                H_IDLE: begin
                    sclk_q <= 1'b0; // [RULE10]
                    if (wr_i && addr_i == ADDR_CMD) begin
                        cs_n_q    <= 1'b0; // [RULE1] [RULE6]
                        si_q      <= wdata_i[23];
                        tx_q      <= {wdata_i[22:0], 1'b0};
                        bit_cnt_q <= 5'h0;
                        state_q   <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tick) begin
                        sclk_q  <= 1'b1;
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_q    <= 1'b0;
                        rx_q      <= {rx_q[22:0], sync2_q[2]}; // [RULE9]
                        bit_cnt_q <= bit_cnt_q + 5'h1;
                        state_q   <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        if (bit_cnt_q == 5'(FRAME_BITS)) begin // [RULE12]
                            state_q <= H_LAG;
                        end else begin
                            sclk_q  <= 1'b1;
                            si_q    <= tx_q[23];
                            tx_q    <= {tx_q[22:0], 1'b0};
                            state_q <= H_HIGH;
                        end
                    end
                end
                H_LAG: begin
                    if (tick) begin
                        cs_n_q  <= 1'b1; // [RULE6]
                        state_q <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tick) begin
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_pull_q <= 1'b0;
        end else if (wr_i && addr_i == ADDR_LINE) begin
            wake_pull_q <= wdata_i[0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_STATUS: rdata_o <= {31'h0, state_q != H_IDLE};
                ADDR_RX:     rdata_o <= {8'h0, rx_q};
                ADDR_LINE:   rdata_o <= {29'h0, sync2_q[0], sync2_q[1],
                                         wake_pull_q};
                default:     rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

endmodule

// ==== rtl/sw_mon_device.sv ====
// Purpose: Device end: serial slave, switch status, flag and wake control.
// Assumes: Switch comparators arrive as digital "above 4.0 V" levels.
// Notes: Every pin and level input passes two flops before use.
`timescale 1ns/10ps
module sw_mon_device
    import sw_mon_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    // Comparator results, high when the input is above 4.0 V
    input  wire logic [NUM_DUAL-1:0] dual_polarity_inputs_i,
    input  wire logic [NUM_GND-1:0]  ground_only_inputs_i,
    // Supply and status levels
    input  wire logic                interface_supply_i,
    input  wire logic                thermal_flag_i,
    // Mode indication
    output logic                     sleep_o,
    // Link
    sw_mon_if.device                 link
);
    localparam int SYNC_W = 7 + NUM_DUAL + NUM_GND;

    logic [SYNC_W-1:0]   sync1_q;
    logic [SYNC_W-1:0]   sync2_q;
    logic [3:0]          prev_q;
    logic                cs_s;
    logic                sclk_s;
    logic                si_s;
    logic                int_s;
    logic                wake_s;
    logic                sup_s;
    logic                therm_s;
    logic [NUM_DUAL-1:0] dual_s;
    logic [NUM_GND-1:0]  gnd_s;
    logic [NUM_SW-1:0]   closed;
    logic [NUM_SW-1:0]   ref_q;
    logic                change;
    logic                cs_fall;
    logic                cs_rise;
    logic                sclk_rise;
    logic                sclk_fall;
    logic                wake_req;
    logic                sel_q;
    logic                chg_in_cs_q;
    mode_t               mode_q;
    logic [NUM_DUAL-1:0] pol_q;
    logic [NUM_SW-1:0]   wake_en_q;
    logic [23:0]         tx_q;
    logic [23:0]         rx_q;
    logic                so_q;
    logic                so_oe_q;
    logic                int_oe_q;
    logic                wake_oe_q;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    function automatic logic rose(input logic prev, input logic cur);
        rose = ~prev & cur;
    endfunction

    assign link.so      = so_q;
    assign link.so_oe   = so_oe_q;
    assign link.int_oe  = int_oe_q;
    assign link.wake_oe = wake_oe_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= 4'hf;
        end else begin
            sync1_q <= {link.cs_n, link.sclk, link.si, link.int_n,
                        link.wake_n, interface_supply_i, thermal_flag_i,
                        dual_polarity_inputs_i, ground_only_inputs_i};
            sync2_q <= sync1_q;
            prev_q  <= {cs_s, sclk_s, int_s, wake_s};
        end
    end

    assign cs_s    = sync2_q[SYNC_W-1];
    assign sclk_s  = sync2_q[SYNC_W-2];
    assign si_s    = sync2_q[SYNC_W-3];
    assign int_s   = sync2_q[SYNC_W-4];
    assign wake_s  = sync2_q[SYNC_W-5];
    assign sup_s   = sync2_q[SYNC_W-6];
    assign therm_s = sync2_q[SYNC_W-7];
    assign dual_s  = sync2_q[NUM_GND +: NUM_DUAL];
    assign gnd_s   = sync2_q[NUM_GND-1:0];

    // Polarity 1 means switch to battery. Closed always reads as 1.
    assign closed = {~(dual_s ^ pol_q), // [RULE21] [RULE24] [RULE13]
                     ~gnd_s};           // [RULE22]

    assign change    = |((closed ^ ref_q) & wake_en_q);
    // Without interface supply the serial port is dead.
    assign cs_fall   = fell(prev_q[3], cs_s) & sup_s; // [RULE20]
    assign cs_rise   = rose(prev_q[3], cs_s) & sel_q;
    assign sclk_rise = rose(prev_q[2], sclk_s) & sel_q & ~cs_s; // [RULE11]
    assign sclk_fall = fell(prev_q[2], sclk_s) & sel_q & ~cs_s; // [RULE11]

    assign wake_req = cs_fall                                   // [RULE7]
                    | (fell(prev_q[1], int_s) & sup_s & wake_s) // [RULE17]
                    | (fell(prev_q[0], wake_s)
                       & (~sup_s | int_s))                      // [RULE19]
                    | change;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_q <= '0;
        end else begin
            ref_q <= closed;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= 1'b0;
        end else if (cs_fall) begin
            sel_q <= 1'b1; // [RULE1]
        end else if (cs_rise || !sup_s) begin
            sel_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q    <= MODE_NORMAL;
            wake_oe_q <= 1'b1;
        end else begin
            unique case (mode_q)
                MODE_SLEEP: begin
                    if (wake_req) begin
                        mode_q    <= MODE_NORMAL;
                        wake_oe_q <= 1'b1; // [RULE18]
                    end
                end
                MODE_NORMAL: begin
                    if (cs_rise && rx_q[23:16] == CMD_SLEEP) begin
                        mode_q    <= MODE_SLEEP;
                        wake_oe_q <= 1'b0; // [RULE18]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_o <= 1'b0;
        end else begin
            sleep_o <= (mode_q == MODE_SLEEP);
        end
    end

    // A change during a frame other than a sleep command keeps the flag across the select rise.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chg_in_cs_q <= 1'b0;
        end else if (sel_q && change && mode_q == MODE_NORMAL) begin
            chg_in_cs_q <= 1'b1;
        end else if (cs_fall) begin
            chg_in_cs_q <= 1'b0;
        end
    end

    // Setting wins over clearing when both fall in one cycle.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            int_oe_q <= 1'b0;
        end else if (mode_q == MODE_NORMAL && change) begin
            int_oe_q <= 1'b1; // [RULE15]
        end else if (cs_rise && !chg_in_cs_q) begin
            int_oe_q <= 1'b0; // [RULE5]
        end else if (mode_q == MODE_NORMAL && cs_rise
                     && rx_q[23:16] == CMD_SLEEP) begin
            int_oe_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q    <= 24'h0;
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (cs_fall) begin
            so_oe_q <= 1'b1; // [RULE2]
            so_q    <= 1'b0;
            // Flag shows only this device's own pending event.
            tx_q    <= {int_oe_q, therm_s, closed}; // [RULE2] [RULE16] [RULE23]
        end else if (cs_rise) begin
            so_oe_q <= 1'b0; // [RULE3]
            so_q    <= 1'b0;
        end else if (sclk_rise) begin
            so_q    <= tx_q[FRAME_BITS-1]; // [RULE9] [RULE14]
            tx_q    <= {tx_q[22:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_q <= 24'h0;
        end else if (sclk_fall) begin
            rx_q <= {rx_q[22:0], si_s}; // [RULE8]
        end
    end

    // Commands take effect only at the select rise and only in Normal.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pol_q     <= POL_RESET;
            wake_en_q <= WAKE_EN_RESET;
        end else if (cs_rise && mode_q == MODE_NORMAL) begin
            if (rx_q[23:16] == CMD_SETTINGS) begin
                pol_q <= rx_q[NUM_DUAL-1:0]; // [RULE4]
            end else if (rx_q[23:16] == CMD_WAKE_INT) begin
                wake_en_q <= rx_q[NUM_SW-1:0]; // [RULE4]
            end
        end
    end

endmodule

// ==== testbench/sw_mon_props.sv ====
// Purpose: Pin-level checker for the switch monitor link.
// Assumes: Device sees pin edges about three clocks late.
// Notes: Interface supply is present whenever the host runs frames.
`timescale 1ns/10ps
module sw_mon_props (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Link
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       so,
    input  wire logic       so_oe,
    input  wire logic       int_oe,
    input  wire logic       wake_oe,
    input  wire logic       int_n,
    input  wire logic       wake_n
);
    logic       sclk_q;
    logic [5:0] falls_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Falling clock edges counted inside one frame.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            falls_q <= 6'h00;
        end else if (cs_n) begin
            falls_q <= 6'h00;
        end else if (sclk_q && !sclk) begin
            falls_q <= falls_q + 6'h01;
        end
    end

    a_so_on_fall: assert property ($fell(cs_n) |-> ##[2:5] so_oe)
        else $error("output not enabled after select fall");
    a_so_off_rise: assert property ($rose(cs_n) |-> ##[2:5] !so_oe)
        else $error("output still enabled after select rise");
    a_so_idle_off: assert property (cs_n [*6] |-> !so_oe)
        else $error("output driven while deselected");
    a_so_steady_low: assert property (
        $fell(sclk) |-> ##1 $stable(so) [*8])
        else $error("serial output moved while clock low");
    a_cs_sclk_low: assert property ($changed(cs_n) |-> !sclk)
        else $error("select moved with clock high");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("clock high while deselected");
    a_frame_bits: assert property ($rose(cs_n) |-> falls_q == 6'h18)
        else $error("frame did not carry 24 bits");
    a_sleep_flag: assert property ($fell(wake_oe) |-> ##[0:2] !int_oe)
        else $error("flag still pulled on entering sleep");
    a_cs_wake: assert property (!wake_oe && $fell(cs_n) |-> ##[2:6] wake_oe)
        else $error("select fall did not wake");
    a_line_wake: assert property (!wake_oe && $fell(wake_n) && int_n
        |-> ##[2:6] wake_oe)
        else $error("wake line fall did not wake");

    c_frame: cover property ($fell(cs_n));
    c_sleep: cover property ($fell(wake_oe));
    c_wake: cover property ($rose(wake_oe));
    c_flag: cover property ($rose(int_oe));
endmodule

// ==== testbench/test_switch_monitor_serial_port.sv ====
// Purpose: Host and device joined on one link, driven from software.
// Assumes: Thermal level dropped once; supply dropped only for a wake test.
// Notes: Expected status is built from the switch levels set here.
`timescale 1ns/10ps
module test_switch_monitor_serial_port
    import sw_mon_pkg::*;
;
    logic                mclk_i;
    logic                rst_i;
    logic [3:0]          addr_i;
    logic [31:0]         wdata_i;
    logic                wr_i;
    logic                rd_i;
    logic [31:0]         rdata_o;
    logic [NUM_DUAL-1:0] dual_lvl;
    logic [NUM_GND-1:0]  gnd_lvl;
    logic                supply;
    logic                therm;
    logic                sleep_o;
    logic [31:0]         rx;
    logic [31:0]         want;
    int                  miscompares;
    int                  n_tests;

    sw_mon_if i_sw_mon_if ();
    sw_mon_host i_sw_mon_host (.mclk_i(mclk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .link(i_sw_mon_if));
    sw_mon_device i_sw_mon_device (.mclk_i(mclk_i), .rst_i(rst_i),
        .dual_polarity_inputs_i(dual_lvl), .ground_only_inputs_i(gnd_lvl),
        .interface_supply_i(supply), .thermal_flag_i(therm),
        .sleep_o(sleep_o), .link(i_sw_mon_if));
    sw_mon_props i_sw_mon_props (.mclk_i(mclk_i), .rst_i(rst_i),
        .cs_n(i_sw_mon_if.cs_n), .sclk(i_sw_mon_if.sclk),
        .so(i_sw_mon_if.so), .so_oe(i_sw_mon_if.so_oe),
        .int_oe(i_sw_mon_if.int_oe), .wake_oe(i_sw_mon_if.wake_oe),
        .int_n(i_sw_mon_if.int_n), .wake_n(i_sw_mon_if.wake_n));

    always #50 mclk_i = ~mclk_i;

    task automatic complete_run;
        $display("mismatches %0d of %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask

    // Busy is polled with a bound so a stuck frame cannot hang the run.
    task automatic frame(input logic [23:0] cmd);
        logic [31:0] st;
        sw_wr(ADDR_CMD, {8'h00, cmd});
        st = 32'h1;
        for (int i = 0; i < 200 && st[0] !== 1'b0; i++) begin
            repeat (4) @(posedge mclk_i);
            sw_rd(ADDR_STATUS, st);
        end
        if (st[0] !== 1'b0) begin
            miscompares++;
            $display("BAD %0t frame never finished", $time);
        end
        sw_rd(ADDR_RX, rx);
    endtask

    task automatic line_chk(input logic [2:0] exp);
        logic [31:0] v;
        repeat (10) @(posedge mclk_i);
        sw_rd(ADDR_LINE, v);
        check(v, {29'h0, exp});
    endtask

    function automatic logic [31:0] stat(input logic f, input logic [7:0] p);
        return {8'h00, f, therm, ~(dual_lvl ^ p), ~gnd_lvl};
    endfunction

    initial begin
        mclk_i = 1'b0;
        rst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        dual_lvl = 8'h00;
        gnd_lvl = 14'h3fff;
        supply = 1'b1;
        therm = 1'b1;
        miscompares = 0;
        n_tests = 0;
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        // The switch reference starts clear, so reset leaves the flag pulled.
        line_chk(3'b000);
        @(posedge mclk_i);
        dual_lvl <= 8'ha5;
        gnd_lvl <= 14'h3ff0;
        line_chk(3'b000);
        frame({CMD_SETTINGS, 16'h000f});
        check(rx, stat(1'b1, POL_RESET));
        line_chk(3'b000);
        frame(24'h000000);
        check(rx, stat(1'b1, 8'h0f));
        line_chk(3'b010);
        want = stat(1'b0, 8'h0f);
        // A switch moves mid-frame; the word keeps the levels seen at select.
        fork
            frame(24'h000000);
            begin
                repeat (100) @(posedge mclk_i);
                gnd_lvl <= 14'h3ff1;
            end
        join
        check(rx, want);
        line_chk(3'b000);
        @(posedge mclk_i);
        therm <= 1'b0;
        frame(24'h000000);
        check(rx, stat(1'b1, 8'h0f));
        line_chk(3'b010);
        frame({CMD_SLEEP, 16'h0000});
        line_chk(3'b110);
        check({31'h0, sleep_o}, 32'h1);
        sw_wr(ADDR_LINE, 32'h1);
        line_chk(3'b011);
        check({31'h0, sleep_o}, 32'h0);
        sw_wr(ADDR_LINE, 32'h0);
        line_chk(3'b010);
        frame({CMD_SLEEP, 16'h0000});
        frame(24'h000000);
        line_chk(3'b010);
        check({31'h0, sleep_o}, 32'h0);
        frame({CMD_SLEEP, 16'h0000});
        @(posedge mclk_i);
        supply <= 1'b0;
        line_chk(3'b110);
        sw_wr(ADDR_LINE, 32'h1);
        line_chk(3'b011);
        check({31'h0, sleep_o}, 32'h0);
        sw_wr(ADDR_LINE, 32'h0);
        @(posedge mclk_i);
        supply <= 1'b1;
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge mclk_i);
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
endmodule
